// file: core/kbh_defines.vh
// Purpose: Constants for the keyboard controller host interface.
// Assumes: Byte-wide host and controller ports on one 50 MHz clock.
// Notes:   Offsets are host I/O addresses.
`ifndef KBH_DEFINES_VH
`define KBH_DEFINES_VH
`define KBH_DATA_PORT        8'h60
`define KBH_CMD_STAT_PORT    8'h64
`define KBH_ADDR_TWO_BIT     2
`define KBH_STAT_OBF         0
`define KBH_STAT_IBF         1
`define KBH_STAT_CD          3
`define KBH_STAT_RESET       8'h00
`define KBH_STAT_FW_MASK     8'hF4
`define KBH_CLK_MHZ          50
`define KBH_PULLUP_HOLD_NS   500
`define KBH_PULLUP_HOLD_CYC  ((`KBH_PULLUP_HOLD_NS * `KBH_CLK_MHZ) / 1000)
`define KBH_FIFO_DEPTH       4
`define KBH_PWR_RUN          2'h0
`define KBH_PWR_SOFT         2'h1
`define KBH_PWR_HARD         2'h2
`endif

// file: core/kbh_fifo.v
// Purpose: Small valid/ready FIFO for the controller-to-host byte stream.
// Assumes: Single clock, asynchronous active-high reset.
// Notes:   Depth must be a power of two.
`timescale 1ns/1ns
module kbh_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;

  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// file: core/kbh_host_if.v
// Purpose: Host mailbox, status, interrupt outputs and port pins of a keyboard controller.
// Assumes: Host strobes and controller CPU strobes are one-cycle pulses on clk.
// Notes:   Controller writes to the output buffer queue in a FIFO; the head is the
//          byte the host sees at the data port.
`timescale 1ns/1ns
`include "kbh_defines.vh"
module kbh_host_if #(
  parameter HOLD_CYC = `KBH_PULLUP_HOLD_CYC,
  parameter DEPTH    = `KBH_FIFO_DEPTH
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Host I/O port
  input  wire [7:0] host_addr,
  input  wire       host_wr,
  input  wire       host_rd,
  input  wire [7:0] host_wdata,
  output reg  [7:0] host_rdata,
  // Controller CPU side
  input  wire       cpu_obuf_wr,
  input  wire [7:0] cpu_obuf_wdata,
  output wire       cpu_obuf_ready,
  input  wire       cpu_ibuf_rd,
  output reg  [7:0] cpu_ibuf_rdata,
  input  wire       cpu_stat_wr,
  input  wire [7:0] cpu_stat_wdata,
  output wire [7:0] cpu_status,
  input  wire       cpu_en_flags,
  input  wire       cpu_clr_obf,
  input  wire [7:0] cpu_port2,
  input  wire [7:0] cpu_port1_mask,
  input  wire       open_drain_mode,
  // Controller CPU core sense and power
  output wire       first_test_input,
  output wire       second_test_input,
  output wire       kbd_data_sense_bit,
  output wire       mouse_data_sense_bit,
  input  wire       cpu_halt,
  input  wire       cpu_stop,
  input  wire       ibf_irq_enable,
  input  wire       timer_overflow,
  output wire       alu_clk_enable,
  output wire       osc_enable,
  output reg        wake_call_irq,
  output reg        wake_continue,
  output wire       cpu_irq_ibf,
  output wire       cpu_irq_timer,
  // Host interrupts and gate
  output reg        keyboard_interrupt_out,
  output reg        mouse_interrupt_out,
  output wire       address_line_gate,
  // General port pins a, b, c
  input  wire [2:0] gp_pin_in,
  output reg  [2:0] gp_pin_out,
  output reg  [2:0] gp_pin_oe,
  // Keyboard and mouse open-drain pins
  input  wire       keyboard_clock_pin_in,
  output wire       keyboard_clock_pin_oe,
  input  wire       keyboard_data_pin_in,
  output wire       keyboard_data_pin_oe,
  input  wire       mouse_clock_pin_in,
  output wire       mouse_clock_pin_oe,
  input  wire       mouse_data_pin_in,
  output wire       mouse_data_pin_oe
);

  //////////////////////////////////////////////////////////////////////////////
  // Mailbox state

  reg  [7:0] controller_input_buffer;
  reg  [7:0] status;
  reg        output_buffer_full;
  reg        en_flags;
  reg  [1:0] pwr_state;
  wire       input_buffer_full;
  wire       host_data_wr;
  wire       host_cmd_wr;
  wire       host_any_wr;
  wire       host_data_rd;
  wire       host_stat_rd;
  wire       fifo_valid;
  wire [7:0] fifo_data;
  wire       host_pop;

  function is_port;
    input [7:0] a;
    input [7:0] p;
    begin
      is_port = (a == p);
    end
  endfunction

  assign host_data_wr = host_wr && is_port(host_addr, `KBH_DATA_PORT);
  assign host_cmd_wr  = host_wr && is_port(host_addr, `KBH_CMD_STAT_PORT);
  assign host_any_wr  = host_data_wr || host_cmd_wr;
  assign host_data_rd = host_rd && is_port(host_addr, `KBH_DATA_PORT);
  assign host_stat_rd = host_rd && is_port(host_addr, `KBH_CMD_STAT_PORT);

  assign input_buffer_full = status[`KBH_STAT_IBF];
  assign cpu_status        = status;

  // Enhanced flag mode latches once firmware executes its enable.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      en_flags <= 1'b0;
    end else if (cpu_en_flags) begin
      en_flags <= 1'b1;
    end
  end

  // Host writes load the input buffer and qualify C/D from address line two.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      controller_input_buffer <= 8'h00;
    end else if (host_any_wr) begin
      controller_input_buffer <= host_wdata;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_ibuf_rdata <= 8'h00;
    end else if (cpu_ibuf_rd) begin
      cpu_ibuf_rdata <= controller_input_buffer;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output buffer queue

  // The host pops on a data read and the flag drops; in plain mode firmware may
  // also drop it early, and only enhanced mode raises it again for queued bytes.
  assign host_pop = host_data_rd && fifo_valid;

  kbh_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .AW    (2)
  ) u_obuf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (cpu_obuf_wr),
    .in_ready  (cpu_obuf_ready),
    .in_data   (cpu_obuf_wdata),
    .out_valid (fifo_valid),
    .out_ready (host_pop),
    .out_data  (fifo_data)
  );

  // Set wins over clear: a new byte keeps the flag up; a queued byte raises it again only in enhanced mode.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      output_buffer_full <= 1'b0;
    end else if (cpu_obuf_wr && cpu_obuf_ready) begin
      output_buffer_full <= 1'b1;
    end else if (host_data_rd) begin
      output_buffer_full <= 1'b0;
    end else if (cpu_clr_obf && !en_flags) begin
      output_buffer_full <= 1'b0;
    end else if (!output_buffer_full && fifo_valid && en_flags) begin
      output_buffer_full <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status register

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= `KBH_STAT_RESET;
    end else begin
      if (cpu_stat_wr) begin
        status <= (status & ~`KBH_STAT_FW_MASK) | (cpu_stat_wdata & `KBH_STAT_FW_MASK);
      end
      status[`KBH_STAT_OBF] <= output_buffer_full;
      if (host_any_wr) begin
        status[`KBH_STAT_CD]  <= host_addr[`KBH_ADDR_TWO_BIT];
        status[`KBH_STAT_IBF] <= 1'b1;
      end else if (cpu_ibuf_rd) begin
        status[`KBH_STAT_IBF] <= 1'b0;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      host_rdata <= 8'h00;
    end else if (host_stat_rd) begin
      host_rdata <= {status[7:1], output_buffer_full};
    end else if (host_data_rd) begin
      host_rdata <= fifo_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Host interrupt outputs

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      keyboard_interrupt_out <= 1'b0;
      mouse_interrupt_out    <= 1'b0;
    end else if (en_flags) begin
      keyboard_interrupt_out <= cpu_port2[4] & output_buffer_full;
      mouse_interrupt_out    <= cpu_port2[5] & ~input_buffer_full;
    end else begin
      keyboard_interrupt_out <= cpu_port2[4];
      mouse_interrupt_out    <= cpu_port2[5];
    end
  end

  assign address_line_gate = cpu_port2[1];

  //////////////////////////////////////////////////////////////////////////////
  // General port pins with timed active pull-up

  // Pin mode comes only from these controls, so there is no input or invert
  // path for general-purpose configuration to reach.
  wire [2:0] gp_bit;
  assign gp_bit = {cpu_port1_mask[7], cpu_port1_mask[6], cpu_port1_mask[2]};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gp_drv
      reg [15:0] hold_cnt;
      reg        last_bit;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          hold_cnt      <= 16'h0000;
          last_bit      <= 1'b0;
          gp_pin_out[g] <= 1'b0;
          gp_pin_oe[g]  <= 1'b1;
        end else begin
          last_bit <= gp_bit[g];
          if (!gp_bit[g]) begin
            gp_pin_out[g] <= 1'b0;
            gp_pin_oe[g]  <= 1'b1;
            hold_cnt      <= 16'h0000;
          end else if (open_drain_mode) begin
            gp_pin_oe[g]  <= 1'b0;
            hold_cnt      <= 16'h0000;
          end else if (!last_bit) begin
            gp_pin_out[g] <= 1'b1;
            gp_pin_oe[g]  <= 1'b1;
            hold_cnt      <= HOLD_CYC[15:0];
          end else if (hold_cnt > 16'h0001) begin
            hold_cnt      <= hold_cnt - 16'h0001;
          end else begin
            hold_cnt      <= 16'h0000;
            gp_pin_oe[g]  <= 1'b0;
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Keyboard and mouse lines

  // Port bit one pulls the wire low; pin levels feed back to the core.
  assign keyboard_clock_pin_oe = cpu_port2[6];
  assign keyboard_data_pin_oe  = cpu_port2[7];
  assign mouse_clock_pin_oe    = cpu_port2[3];
  assign mouse_data_pin_oe     = cpu_port2[2];
  assign first_test_input      = keyboard_clock_pin_in;
  assign kbd_data_sense_bit    = keyboard_data_pin_in;
  assign second_test_input     = mouse_clock_pin_in;
  assign mouse_data_sense_bit  = mouse_data_pin_in;

  //////////////////////////////////////////////////////////////////////////////
  // Power-down and core interrupts

  assign cpu_irq_ibf   = input_buffer_full & ibf_irq_enable;
  assign cpu_irq_timer = timer_overflow;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_state     <= `KBH_PWR_RUN;
      wake_call_irq <= 1'b0;
      wake_continue <= 1'b0;
    end else begin
      wake_call_irq <= 1'b0;
      wake_continue <= 1'b0;
      case (pwr_state)
        `KBH_PWR_RUN: begin
          if (cpu_stop) begin
            pwr_state <= `KBH_PWR_HARD;
          end else if (cpu_halt) begin
            pwr_state <= `KBH_PWR_SOFT;
          end
        end
        `KBH_PWR_SOFT, `KBH_PWR_HARD: begin
          if (host_any_wr) begin
            pwr_state     <= `KBH_PWR_RUN;
            wake_call_irq <= ibf_irq_enable;
            wake_continue <= ~ibf_irq_enable;
          end
        end
        default: pwr_state <= `KBH_PWR_RUN;
      endcase
    end
  end

  assign alu_clk_enable = (pwr_state == `KBH_PWR_RUN);
  assign osc_enable     = (pwr_state != `KBH_PWR_HARD);

  // Pin inputs of general ports are not used by this block.
  wire unused_gp = |gp_pin_in;

endmodule

// file: bench/kbh_host_if_properties.sv
// Purpose: Concurrent checks on the ports of the keyboard host interface.
// Assumes: One clock, rst asynchronous and active high.
// Notes:   Enhanced flag mode is tracked here from its enable strobe.
`timescale 1ns/1ns
module kbh_host_if_properties #(
  parameter HOLD_CYC = 25
) (
  // Clock and reset
  input wire       clk,
  input wire       rst,
  // Host and controller inputs
  input wire [7:0] host_addr,
  input wire       host_wr,
  input wire       cpu_en_flags,
  input wire [7:0] cpu_port2,
  input wire [7:0] cpu_port1_mask,
  input wire       open_drain_mode,
  input wire       cpu_halt,
  input wire       cpu_stop,
  // Outputs under check
  input wire       alu_clk_enable,
  input wire       osc_enable,
  input wire       keyboard_interrupt_out,
  input wire       mouse_interrupt_out,
  input wire       address_line_gate,
  input wire [2:0] gp_pin_out,
  input wire [2:0] gp_pin_oe,
  input wire       keyboard_clock_pin_oe,
  input wire       keyboard_data_pin_oe,
  input wire       mouse_clock_pin_oe,
  input wire       mouse_data_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reg       en_on;
  reg [7:0] hi_cnt;
  ////////////////////////////////////////////////////////////////////////
  // The active high drive must end, or a shared pin would be fought over.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      en_on  <= 1'b0;
      hi_cnt <= 8'h00;
    end else begin
      en_on  <= en_on | cpu_en_flags;
      hi_cnt <= (gp_pin_oe[2] && gp_pin_out[2]) ? hi_cnt + 8'h01 : 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  chk_keyboard_interrupt_out_plain:
    assert property (!en_on && !cpu_en_flags && $stable(cpu_port2[4])
      |-> keyboard_interrupt_out == cpu_port2[4]) else $error("kbd irq not port bit");
  chk_keyboard_interrupt_out_masked:
    assert property (en_on && !cpu_port2[4] && $stable(cpu_port2[4])
      |-> !keyboard_interrupt_out) else $error("kbd irq not forced low");
  chk_mouse_interrupt_out_plain:
    assert property (!en_on && !cpu_en_flags && $stable(cpu_port2[5])
      |-> mouse_interrupt_out == cpu_port2[5]) else $error("mouse irq not port bit");
  chk_mouse_interrupt_out_host:
    assert property (en_on && cpu_port2[5] && host_wr && host_addr == 8'h60
      |-> ##[1:3] !mouse_interrupt_out) else $error("mouse irq not inverted full");
  chk_gate_follow:
    assert property (address_line_gate == cpu_port2[1]) else $error("gate mismatch");
  chk_kbd_pins:
    assert property (keyboard_clock_pin_oe == cpu_port2[6]
      && keyboard_data_pin_oe == cpu_port2[7]) else $error("keyboard pin mismatch");
  chk_mouse_pins:
    assert property (mouse_clock_pin_oe == cpu_port2[3]
      && mouse_data_pin_oe == cpu_port2[2]) else $error("mouse pin mismatch");
  chk_drive_start:
    assert property (!open_drain_mode && $rose(cpu_port1_mask[7])
      |-> ##[1:2] gp_pin_oe[2] && gp_pin_out[2]) else $error("no high drive");
  chk_drive_limit:
    assert property (hi_cnt <= HOLD_CYC + 1) else $error("high drive too long");
  chk_od_level:
    assert property (open_drain_mode && $stable(open_drain_mode)
      && $stable(cpu_port1_mask[7]) |-> gp_pin_oe[2] == !cpu_port1_mask[7]
      && !(gp_pin_oe[2] && gp_pin_out[2])) else $error("open drain drove high");
  chk_halt_alu:
    assert property (cpu_halt |-> ##[1:2] !alu_clk_enable) else $error("alu clock runs");
  chk_stop_osc:
    assert property (cpu_stop |-> ##[1:2] !osc_enable) else $error("oscillator runs");
endmodule

// file: bench/kbh_host_model.sv
// Purpose: Host processor model for the data and command/status ports.
// Assumes: One-cycle strobes launched 1 ns after the rising edge.
// Notes:   Released address and data lines carry the inverse of the last value, never a stale copy; strobes return low.
`timescale 1ns/1ns
module kbh_host_model (
  // Clock
  input  wire       clk,
  // Host port
  output reg  [7:0] host_addr,
  output reg        host_wr,
  output reg        host_rd,
  output reg  [7:0] host_wdata
);
  initial begin
    host_addr  = 8'h00;
    host_wr    = 1'b0;
    host_rd    = 1'b0;
    host_wdata = 8'h00;
  end
  task acc(input [7:0] a, input [7:0] d, input w);
    @(posedge clk);
    #1;
    host_addr  = a;
    host_wdata = d;
    host_wr    = w;
    host_rd    = !w;
    @(posedge clk);
    #1;
    host_wr    = 1'b0;
    host_rd    = 1'b0;
    host_addr  = ~a;
    host_wdata = ~d;
  endtask
endmodule

// file: bench/testbench.sv
// Purpose: Self-checking bench for the keyboard host interface.
// Assumes: Pull-ups on every shared pin; short high-drive hold for speed.
// Notes:   Expected reads are queued by the driver and popped by a watcher.
`timescale 1ns/1ns
module testbench;
  localparam HOLD = 3;
  reg        clk, rst, cpu_obuf_wr, cpu_ibuf_rd, cpu_stat_wr, cpu_en_flags, cpu_clr_obf;
  reg        open_drain_mode, cpu_halt, cpu_stop, ibf_irq_enable, timer_overflow;
  reg  [7:0] cpu_obuf_wdata, cpu_stat_wdata, cpu_port2, cpu_port1_mask, d, b [0:3];
  wire [7:0] host_addr, host_wdata, host_rdata, cpu_ibuf_rdata, cpu_status;
  wire       host_wr, host_rd, cpu_obuf_ready, first_test_input, second_test_input;
  wire       kbd_data_sense_bit, mouse_data_sense_bit, alu_clk_enable, osc_enable;
  wire       wake_call_irq, wake_continue, cpu_irq_ibf, cpu_irq_timer, address_line_gate;
  wire       keyboard_interrupt_out, mouse_interrupt_out;
  wire [2:0] gp_pin_in, gp_pin_out, gp_pin_oe;
  wire       keyboard_clock_pin_in, keyboard_clock_pin_oe, keyboard_data_pin_in;
  wire       keyboard_data_pin_oe, mouse_clock_pin_in, mouse_clock_pin_oe;
  wire       mouse_data_pin_in, mouse_data_pin_oe;
  reg        rd_d = 1'b0;
  reg        crd_d = 1'b0;
  int        fail_count = 0;
  int        check_count = 0;
  int        i, n;
  logic [7:0] exp_h[$], exp_c[$];
  assign keyboard_clock_pin_in = !keyboard_clock_pin_oe;
  assign keyboard_data_pin_in  = !keyboard_data_pin_oe;
  assign mouse_clock_pin_in    = !mouse_clock_pin_oe;
  assign mouse_data_pin_in     = !mouse_data_pin_oe;
  assign gp_pin_in             = (gp_pin_oe & gp_pin_out) | ~gp_pin_oe;
  kbh_host_if #(.HOLD_CYC(HOLD)) u_dut (.*);
  kbh_host_model u_host (.*);
  always #10 clk = !clk;
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task cpu(input int k, input [7:0] v);
    @(posedge clk);
    #1;
    cpu_obuf_wdata = v;
    cpu_stat_wdata = v;
    case (k)
      0: cpu_obuf_wr = 1'b1;
      1: cpu_ibuf_rd = 1'b1;
      2: cpu_stat_wr = 1'b1;
      3: cpu_en_flags = 1'b1;
      4: cpu_halt = 1'b1;
      6: cpu_clr_obf = 1'b1;
      default: cpu_stop = 1'b1;
    endcase
    @(posedge clk);
    #1;
    {cpu_obuf_wr, cpu_ibuf_rd, cpu_stat_wr, cpu_en_flags, cpu_halt, cpu_stop, cpu_clr_obf} = 7'h00;
  endtask
  task stat(input [7:0] e);
    exp_h.push_back(e);
    u_host.acc(8'h64, 8'h00, 1'b0);
  endtask
  task wt(input bit k);
    n = 0;
    while (n < 50 && (k ? wake_continue : wake_call_irq) !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h00, n < 50}, 8'h01);
    if (n >= 50) give_verdict;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rd_d) chk(host_rdata, exp_h.pop_front());
    if (crd_d) chk(cpu_ibuf_rdata, exp_c.pop_front());
    rd_d  <= host_rd;
    crd_d <= cpu_ibuf_rd;
  end
  initial begin
    {clk, cpu_obuf_wr, cpu_ibuf_rd, cpu_stat_wr, cpu_en_flags, cpu_clr_obf} = 6'h00;
    {open_drain_mode, cpu_halt, cpu_stop, ibf_irq_enable, timer_overflow} = 5'h00;
    {cpu_obuf_wdata, cpu_stat_wdata, cpu_port2, cpu_port1_mask} = 32'h0;
    rst = 1'b1;
    i = $urandom(33415);
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({7'h00, keyboard_interrupt_out}, 8'h00);
    stat(8'h00);
    for (i = 0; i < 2; i++) begin
      d = $urandom;
      u_host.acc(i ? 8'h60 : 8'h64, d, 1'b1);
      stat(i ? 8'h02 : 8'h0A);
      exp_c.push_back(d);
      cpu(1, 8'h00);
      stat(i ? 8'h00 : 8'h08);
    end
    u_host.acc(8'h61, 8'h5A, 1'b1);
    cpu(2, 8'hFF);
    stat(8'hF4);
    chk(cpu_status, 8'hF4);
    cpu(2, 8'h00);
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      open_drain_mode = i[0];
      timer_overflow  = i[1];
      cpu_port1_mask  = $urandom;
      cpu_port2       = $urandom;
      repeat (HOLD + 4) @(posedge clk);
      #1;
      d = {5'h00, cpu_port1_mask[7], cpu_port1_mask[6], cpu_port1_mask[2]};
      chk({5'h00, gp_pin_in}, d);
      chk({5'h00, ~gp_pin_oe}, d);
      chk({4'h0, first_test_input, kbd_data_sense_bit, second_test_input,
           mouse_data_sense_bit}, ~{4'hF, cpu_port2[6], cpu_port2[7], cpu_port2[3],
           cpu_port2[2]});
      chk({7'h00, cpu_irq_timer}, {7'h00, timer_overflow});
      chk({7'h00, keyboard_interrupt_out}, {7'h00, cpu_port2[4]});
      chk({7'h00, mouse_interrupt_out}, {7'h00, cpu_port2[5]});
    end
    d = $urandom;
    cpu(0, d);
    stat(8'h01);
    exp_h.push_back(d);
    u_host.acc(8'h60, 8'h00, 1'b0);
    stat(8'h00);
    cpu(0, 8'hA5);
    cpu(6, 8'h00);
    stat(8'h00);
    exp_h.push_back(8'hA5);
    u_host.acc(8'h60, 8'h00, 1'b0);
    cpu_port2 = 8'h30;
    cpu(3, 8'h00);
    n = 0;
    while (cpu_obuf_ready === 1'b1 && n < 8) begin
      b[n % 4] = $urandom;
      cpu(0, b[n % 4]);
      n++;
    end
    chk(n, 8'h04);
    cpu(0, 8'hEE);
    chk({7'h00, keyboard_interrupt_out}, 8'h01);
    stat(8'h01);
    for (i = 0; i < 4; i++) begin
      exp_h.push_back(b[i]);
      u_host.acc(8'h60, 8'h00, 1'b0);
    end
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, keyboard_interrupt_out}, 8'h00);
    stat(8'h00);
    ibf_irq_enable = 1'b1;
    for (i = 0; i < 2; i++) begin
      cpu(i ? 5 : 4, 8'h00);
      chk({6'h00, osc_enable, alu_clk_enable}, i ? 8'h00 : 8'h02);
      d = $urandom;
      u_host.acc(8'h60, d, 1'b1);
      wt(i);
      @(posedge clk);
      #1;
      chk({6'h00, cpu_irq_ibf, mouse_interrupt_out}, {6'h00, !i[0], 1'b0});
      ibf_irq_enable = 1'b0;
      exp_c.push_back(d);
      cpu(1, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      chk({7'h00, mouse_interrupt_out}, 8'h01);
    end
    cpu_port2 = 8'h20;
    cpu(0, 8'h3C);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, keyboard_interrupt_out}, 8'h00);
    stat(8'h01);
    @(posedge clk);
    #1;
    give_verdict;
  end
endmodule
bind kbh_host_if kbh_host_if_properties #(.HOLD_CYC(HOLD_CYC)) u_chk (.*);
